// ==== adu_cfg.svh ====
`ifndef ADU_CFG_SVH
`define ADU_CFG_SVH

// link command codes
`define ADU_SYNC_BYTE 8'h55
`define ADU_CMD_RESET 8'h06
`define ADU_CMD_SLEEP 8'h02
`define ADU_CMD_START 8'h08
`define ADU_CMD_RDATA 8'h10
`define ADU_CMD_REGISTER_WRITE_CMD_HI 4'h4
`define ADU_CMD_REGISTER_READBACK_CMD_HI 4'h2

// configuration store
`define ADU_NREG 5
`define ADU_REG_RST 8'h00
`define ADU_REG_MUX 3'h0
`define ADU_REG_MODE 3'h1
`define ADU_REG_PINS 3'h4
`define ADU_SEL_MSB 7
`define ADU_SEL_LSB 4
`define ADU_SEL_SHORT 4'he
`define ADU_CONT_BIT 3
`define ADU_RDY_SEL_BIT 3
`define ADU_DIR_LSB 4
`define ADU_RDY_PIN 2

// timing
`define ADU_CLK_MHZ 20
`define ADU_RSRX_NS 50000
`define ADU_CONV_US 500
`define ADU_BAUD_RST 20'h000a7
`define ADU_RX_EDGES 3'h3

`endif

// ==== adu_pkg.sv ====
package adu_pkg;
	typedef enum logic [2:0] {ADU_RX_IDLE, ADU_RX_BAUD, ADU_RX_TAIL, ADU_RX_START,
		ADU_RX_DATA, ADU_RX_STOP} adu_rx_st_t;
	typedef enum logic [1:0] {ADU_CM_SYNC, ADU_CM_CMD, ADU_CM_WDATA, ADU_CM_HOLD} adu_cm_st_t;
	typedef enum logic {ADU_TX_IDLE, ADU_TX_BUSY} adu_tx_st_t;
endpackage

// ==== adu_buf.sv ====
`timescale 1ns/10ps
// two-entry buffer; in_ready falls only when both entries hold words
module adu_buf #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready
);
	import adu_pkg::*;
	logic [W-1:0] mem_r [2];
	logic [W-1:0] mem_nxt [2];
	logic wp_r, wp_nxt, rp_r, rp_nxt;
	logic [1:0] cnt_r, cnt_nxt;
	logic wr, rd;

	assign in_ready = (cnt_r != 2'h2);
	assign out_valid = (cnt_r != 2'h0);
	assign out_data = mem_r[rp_r];

	always_comb begin
		wr = in_valid & in_ready;
		rd = out_valid & out_ready;
		mem_nxt = mem_r;
		wp_nxt = wp_r;
		rp_nxt = rp_r;
		cnt_nxt = cnt_r;
		if (wr) begin
			mem_nxt[wp_r] = in_data;
			wp_nxt = ~wp_r;
		end
		if (rd) begin
			rp_nxt = ~rp_r;
		end
		if (wr & ~rd) begin
			cnt_nxt = cnt_r + 2'h1;
		end else if (rd & ~wr) begin
			cnt_nxt = cnt_r - 2'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			wp_r <= 1'b0;
			rp_r <= 1'b0;
			cnt_r <= 2'h0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
		mem_r <= mem_nxt;
	end
endmodule

// ==== adu_cmd.sv ====
`timescale 1ns/10ps
`include "adu_cfg.svh"
// Behaviour
// - link characters are 8 data bits, no parity, one stop bit
// - sync, write command 4xh, one data byte stored in selected register
// - sync then read command 2xh returns the selected register contents
// - start command 08h begins conversions, continuous when so configured
// - shared pin as data-ready output goes low on each new result
// - sync then 10h returns the conversion result as two bytes
// - power-down command 02h stops converting and enters sleep
// - input selector 1110 shorts both converter inputs to mid-supply
// - after reset every general pin acts as an input
// - receive baud rate is measured from each sync byte
// - writing 48h to register 04h makes the shared pin data-ready
module adu_cmd #(
	parameter int CNT_W = 20,
	parameter int CONV_CYC = `ADU_CONV_US * `ADU_CLK_MHZ,
	parameter int RSRX_CYC = (`ADU_RSRX_NS * `ADU_CLK_MHZ + 999) / 1000
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic rx_pin_i,
	output logic tx_pin_o,
	input wire logic [15:0] sample_i,
	input wire logic general_pin_zero_i,
	output logic general_pin_zero_o,
	output logic general_pin_zero_oe,
	input wire logic general_pin_one_i,
	output logic general_pin_one_o,
	output logic general_pin_one_oe,
	input wire logic shared_pin_two_i,
	output logic shared_pin_two_o,
	output logic shared_pin_two_oe,
	output logic converting_o,
	output logic asleep_o,
	output logic short_inputs_o,
	output logic [3:0] input_selector_field_o
);
	import adu_pkg::*;

	// ---------------- receiver with autobaud ----------------
	logic rx_s1_r, rx_s2_r, rx_d_r;
	adu_rx_st_t rx_st_r, rx_st_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt, baud_r, baud_nxt, half;
	logic [2:0] edges_r, edges_nxt, bit_r, bit_nxt;
	logic [7:0] sh_r, sh_nxt, byte_r, byte_nxt;
	logic byte_v_r, byte_v_nxt, sync_v_r, sync_v_nxt;
	logic fall, need_sync;

	assign fall = rx_d_r & ~rx_s2_r;
	assign half = baud_r >> 1;

	always_comb begin
		rx_st_nxt = rx_st_r;
		cnt_nxt = cnt_r + CNT_W'(1);
		edges_nxt = edges_r;
		bit_nxt = bit_r;
		sh_nxt = sh_r;
		baud_nxt = baud_r;
		byte_nxt = byte_r;
		byte_v_nxt = 1'b0;
		sync_v_nxt = 1'b0;
		unique case (rx_st_r)
			ADU_RX_IDLE: begin
				cnt_nxt = '0;
				edges_nxt = 3'h0;
				if (fall) begin
					rx_st_nxt = need_sync ? ADU_RX_BAUD : ADU_RX_START;
				end
			end
			ADU_RX_BAUD: begin
				// 55h gives a falling edge every two bits: four more edges span eight bits
				if (fall) begin
					edges_nxt = edges_r + 3'h1;
					if (edges_r == `ADU_RX_EDGES) begin
						baud_nxt = cnt_nxt >> 3;
						cnt_nxt = '0;
						rx_st_nxt = ADU_RX_TAIL;
					end
				end
			end
			ADU_RX_TAIL: begin
				if (cnt_r == baud_r + half) begin
					sync_v_nxt = rx_s2_r;
					rx_st_nxt = ADU_RX_IDLE;
				end
			end
			ADU_RX_START: begin
				if (cnt_r == half) begin
					cnt_nxt = '0;
					bit_nxt = 3'h0;
					rx_st_nxt = rx_s2_r ? ADU_RX_IDLE : ADU_RX_DATA;
				end
			end
			ADU_RX_DATA: begin
				if (cnt_r == baud_r - CNT_W'(1)) begin
					cnt_nxt = '0;
					sh_nxt = {rx_s2_r, sh_r[7:1]};
					bit_nxt = bit_r + 3'h1;
					if (bit_r == 3'h7) begin
						rx_st_nxt = ADU_RX_STOP;
					end
				end
			end
			ADU_RX_STOP: begin
				if (cnt_r == baud_r - CNT_W'(1)) begin
					// a low stop bit is a framing error: the byte is dropped
					byte_v_nxt = rx_s2_r;
					byte_nxt = sh_r;
					rx_st_nxt = ADU_RX_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			rx_s1_r <= 1'b1;
			rx_s2_r <= 1'b1;
			rx_d_r <= 1'b1;
			rx_st_r <= ADU_RX_IDLE;
			cnt_r <= '0;
			baud_r <= CNT_W'(`ADU_BAUD_RST);
			edges_r <= 3'h0;
			bit_r <= 3'h0;
			sh_r <= 8'h00;
			byte_r <= 8'h00;
			byte_v_r <= 1'b0;
			sync_v_r <= 1'b0;
		end else begin
			rx_s1_r <= rx_pin_i;
			rx_s2_r <= rx_s1_r;
			rx_d_r <= rx_s2_r;
			rx_st_r <= rx_st_nxt;
			cnt_r <= cnt_nxt;
			baud_r <= baud_nxt;
			edges_r <= edges_nxt;
			bit_r <= bit_nxt;
			sh_r <= sh_nxt;
			byte_r <= byte_nxt;
			byte_v_r <= byte_v_nxt;
			sync_v_r <= sync_v_nxt;
		end
	end

	// ---------------- command decoder and register store ----------------
	adu_cm_st_t cm_st_r, cm_st_nxt;
	logic [7:0] cfg_r [`ADU_NREG];
	logic [7:0] cfg_nxt [`ADU_NREG];
	logic [2:0] sel_r, sel_nxt;
	logic [CNT_W-1:0] hold_r, hold_nxt;
	logic start_p_r, start_p_nxt, sleep_p_r, sleep_p_nxt, rst_p_r, rst_p_nxt, rd_p_r, rd_p_nxt;
	logic push_v_r, push_v_nxt, pend_r, pend_nxt;
	logic [7:0] push_b_r, push_b_nxt, pend_b_r, pend_b_nxt, rd_val;
	logic [2:0] pin_sync, pin_s1_r, pin_s2_r, pin_in;
	logic buf_in_ready;
	logic [15:0] result_r;

	assign need_sync = (cm_st_r != ADU_CM_CMD) && (cm_st_r != ADU_CM_WDATA);
	assign pin_in = {shared_pin_two_i, general_pin_one_i, general_pin_zero_i};
	assign pin_sync = pin_s2_r;

	always_comb begin
		rd_val = cfg_r[byte_r[3:1]];
		// pin register reads back the live level of pins set as inputs
		if (byte_r[3:1] == `ADU_REG_PINS) begin
			rd_val[2:0] = (cfg_r[`ADU_REG_PINS][6:4] & cfg_r[`ADU_REG_PINS][2:0])
				| (~cfg_r[`ADU_REG_PINS][6:4] & pin_sync);
		end
	end

	always_comb begin
		cm_st_nxt = cm_st_r;
		cfg_nxt = cfg_r;
		sel_nxt = sel_r;
		hold_nxt = hold_r + CNT_W'(1);
		start_p_nxt = 1'b0;
		sleep_p_nxt = 1'b0;
		rst_p_nxt = 1'b0;
		rd_p_nxt = 1'b0;
		push_v_nxt = push_v_r;
		push_b_nxt = push_b_r;
		pend_nxt = pend_r;
		pend_b_nxt = pend_b_r;
		if (push_v_r && buf_in_ready) begin
			push_v_nxt = pend_r;
			push_b_nxt = pend_b_r;
			pend_nxt = 1'b0;
		end
		unique case (cm_st_r)
			ADU_CM_SYNC: begin
				if (sync_v_r) begin
					cm_st_nxt = ADU_CM_CMD;
				end
			end
			ADU_CM_CMD: begin
				if (byte_v_r) begin
					cm_st_nxt = ADU_CM_SYNC;
					if (byte_r == `ADU_CMD_RESET) begin
						for (int i = 0; i < `ADU_NREG; i++) begin
							cfg_nxt[i] = `ADU_REG_RST;
						end
						rst_p_nxt = 1'b1;
						hold_nxt = '0;
						cm_st_nxt = ADU_CM_HOLD;
					end else if (byte_r == `ADU_CMD_SLEEP) begin
						sleep_p_nxt = 1'b1;
					end else if (byte_r == `ADU_CMD_START) begin
						start_p_nxt = 1'b1;
					end else if (byte_r == `ADU_CMD_RDATA) begin
						// result goes out high byte first
						push_v_nxt = 1'b1;
						push_b_nxt = result_r[15:8];
						pend_nxt = 1'b1;
						pend_b_nxt = result_r[7:0];
						rd_p_nxt = 1'b1;
					end else if (byte_r[7:4] == `ADU_CMD_REGISTER_WRITE_CMD_HI) begin
						if (32'(byte_r[3:1]) < `ADU_NREG) begin
							sel_nxt = byte_r[3:1];
							cm_st_nxt = ADU_CM_WDATA;
						end
					end else if (byte_r[7:4] == `ADU_CMD_REGISTER_READBACK_CMD_HI) begin
						if (32'(byte_r[3:1]) < `ADU_NREG) begin
							push_v_nxt = 1'b1;
							push_b_nxt = rd_val;
						end
					end
				end
			end
			ADU_CM_WDATA: begin
				if (byte_v_r) begin
					cfg_nxt[sel_r] = byte_r;
					cm_st_nxt = ADU_CM_SYNC;
				end
			end
			ADU_CM_HOLD: begin
				// bytes arriving inside the reset-to-receive delay are ignored
				if (hold_r == CNT_W'(RSRX_CYC - 1)) begin
					cm_st_nxt = ADU_CM_SYNC;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			cm_st_r <= ADU_CM_SYNC;
			for (int i = 0; i < `ADU_NREG; i++) begin
				cfg_r[i] <= `ADU_REG_RST;
			end
			sel_r <= 3'h0;
			hold_r <= '0;
			start_p_r <= 1'b0;
			sleep_p_r <= 1'b0;
			rst_p_r <= 1'b0;
			rd_p_r <= 1'b0;
			push_v_r <= 1'b0;
			push_b_r <= 8'h00;
			pend_r <= 1'b0;
			pend_b_r <= 8'h00;
		end else begin
			cm_st_r <= cm_st_nxt;
			cfg_r <= cfg_nxt;
			sel_r <= sel_nxt;
			hold_r <= hold_nxt;
			start_p_r <= start_p_nxt;
			sleep_p_r <= sleep_p_nxt;
			rst_p_r <= rst_p_nxt;
			rd_p_r <= rd_p_nxt;
			push_v_r <= push_v_nxt;
			push_b_r <= push_b_nxt;
			pend_r <= pend_nxt;
			pend_b_r <= pend_b_nxt;
		end
	end

	// ---------------- conversion sequencer ----------------
	logic conv_on_r, conv_on_nxt, asleep_r, asleep_nxt, rdy_n_r, rdy_n_nxt, short_r, short_nxt;
	logic [CNT_W-1:0] conv_cnt_r, conv_cnt_nxt;
	logic [15:0] result_nxt;

	always_comb begin
		conv_on_nxt = conv_on_r;
		asleep_nxt = asleep_r;
		rdy_n_nxt = rdy_n_r;
		conv_cnt_nxt = conv_cnt_r;
		result_nxt = result_r;
		short_nxt = (cfg_r[`ADU_REG_MUX][`ADU_SEL_MSB:`ADU_SEL_LSB] == `ADU_SEL_SHORT);
		if (rd_p_r || rst_p_r) begin
			rdy_n_nxt = 1'b1;
		end
		if (rst_p_r || sleep_p_r) begin
			conv_on_nxt = 1'b0;
			asleep_nxt = sleep_p_r;
		end else if (start_p_r) begin
			conv_on_nxt = 1'b1;
			asleep_nxt = 1'b0;
			conv_cnt_nxt = '0;
		end else if (conv_on_r) begin
			conv_cnt_nxt = conv_cnt_r + CNT_W'(1);
			if (conv_cnt_r == CNT_W'(CONV_CYC - 1)) begin
				conv_cnt_nxt = '0;
				result_nxt = sample_i;
				// a fresh result beats a read-out clear in the same cycle
				rdy_n_nxt = 1'b0;
				conv_on_nxt = cfg_r[`ADU_REG_MODE][`ADU_CONT_BIT];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			conv_on_r <= 1'b0;
			asleep_r <= 1'b0;
			rdy_n_r <= 1'b1;
			conv_cnt_r <= '0;
			result_r <= 16'h0000;
			short_r <= 1'b0;
		end else begin
			conv_on_r <= conv_on_nxt;
			asleep_r <= asleep_nxt;
			rdy_n_r <= rdy_n_nxt;
			conv_cnt_r <= conv_cnt_nxt;
			result_r <= result_nxt;
			short_r <= short_nxt;
		end
	end

	// ---------------- general pins ----------------
	logic [2:0] pin_o_r, pin_oe_r, pin_o_nxt, pin_oe_nxt;
	logic rdy_sel;

	assign rdy_sel = cfg_r[`ADU_REG_PINS][`ADU_RDY_SEL_BIT];

	genvar k;
	generate
		for (k = 0; k < 3; k++) begin : g_pin
			always_comb begin
				pin_oe_nxt[k] = cfg_r[`ADU_REG_PINS][`ADU_DIR_LSB + k];
				pin_o_nxt[k] = cfg_r[`ADU_REG_PINS][k];
				if (k == `ADU_RDY_PIN && rdy_sel) begin
					pin_oe_nxt[k] = 1'b1;
					pin_o_nxt[k] = rdy_n_r;
				end
			end
			always_ff @(posedge clk) begin
				if (!nrst) begin
					pin_s1_r[k] <= 1'b0;
					pin_s2_r[k] <= 1'b0;
					pin_o_r[k] <= 1'b0;
					pin_oe_r[k] <= 1'b0;
				end else begin
					pin_s1_r[k] <= pin_in[k];
					pin_s2_r[k] <= pin_s1_r[k];
					pin_o_r[k] <= pin_o_nxt[k];
					pin_oe_r[k] <= pin_oe_nxt[k];
				end
			end
		end
	endgenerate

	// ---------------- transmitter ----------------
	adu_tx_st_t tx_st_r, tx_st_nxt;
	logic [9:0] tx_sh_r, tx_sh_nxt;
	logic [3:0] tx_n_r, tx_n_nxt;
	logic [CNT_W-1:0] tx_cnt_r, tx_cnt_nxt;
	logic txd_r, txd_nxt, out_v, out_rdy;
	logic [7:0] out_b;

	adu_buf #(.W(8)) u_buf (
		.clk(clk),
		.nrst(nrst),
		.in_valid(push_v_r),
		.in_data(push_b_r),
		.in_ready(buf_in_ready),
		.out_valid(out_v),
		.out_data(out_b),
		.out_ready(out_rdy)
	);

	assign out_rdy = (tx_st_r == ADU_TX_IDLE);

	always_comb begin
		tx_st_nxt = tx_st_r;
		tx_sh_nxt = tx_sh_r;
		tx_n_nxt = tx_n_r;
		tx_cnt_nxt = tx_cnt_r + CNT_W'(1);
		txd_nxt = 1'b1;
		unique case (tx_st_r)
			ADU_TX_IDLE: begin
				if (out_v) begin
					tx_sh_nxt = {1'b1, out_b, 1'b0};
					tx_n_nxt = 4'h0;
					tx_cnt_nxt = '0;
					tx_st_nxt = ADU_TX_BUSY;
				end
			end
			ADU_TX_BUSY: begin
				txd_nxt = tx_sh_r[0];
				if (tx_cnt_r == baud_r - CNT_W'(1)) begin
					tx_cnt_nxt = '0;
					tx_sh_nxt = {1'b1, tx_sh_r[9:1]};
					tx_n_nxt = tx_n_r + 4'h1;
					if (tx_n_r == 4'h9) begin
						tx_st_nxt = ADU_TX_IDLE;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			tx_st_r <= ADU_TX_IDLE;
			tx_sh_r <= 10'h3ff;
			tx_n_r <= 4'h0;
			tx_cnt_r <= '0;
			txd_r <= 1'b1;
		end else begin
			tx_st_r <= tx_st_nxt;
			tx_sh_r <= tx_sh_nxt;
			tx_n_r <= tx_n_nxt;
			tx_cnt_r <= tx_cnt_nxt;
			txd_r <= txd_nxt;
		end
	end

	assign tx_pin_o = txd_r;
	assign {shared_pin_two_o, general_pin_one_o, general_pin_zero_o} = pin_o_r;
	assign {shared_pin_two_oe, general_pin_one_oe, general_pin_zero_oe} = pin_oe_r;
	assign converting_o = conv_on_r;
	assign asleep_o = asleep_r;
	assign short_inputs_o = short_r;
	assign input_selector_field_o = cfg_r[`ADU_REG_MUX][`ADU_SEL_MSB:`ADU_SEL_LSB];
endmodule

// ==== adu_cmd_assertions.sv ====
`timescale 1ns/10ps
module adu_chk (
	input wire logic clk,
	input wire logic nrst,
	input wire logic tx_pin_o,
	input wire logic shared_pin_two_o,
	input wire logic shared_pin_two_oe,
	input wire logic general_pin_zero_oe,
	input wire logic general_pin_one_oe,
	input wire logic converting_o,
	input wire logic asleep_o,
	input wire logic short_inputs_o,
	input wire logic [3:0] input_selector_field_o
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence s_tx_start;
		$fell(tx_pin_o);
	endsequence
	sequence s_rdy_fall;
		shared_pin_two_oe && $fell(shared_pin_two_o);
	endsequence
	a_short_on_sel: assert property (
		(input_selector_field_o == 4'he) [*3] |-> short_inputs_o)
		else $error("inputs not shorted for selector 1110");
	a_short_off_sel: assert property (
		(input_selector_field_o != 4'he) [*3] |-> !short_inputs_o)
		else $error("inputs shorted for another selector");
	a_tx_idle_rst: assert property ($rose(nrst) |-> tx_pin_o && !converting_o)
		else $error("transmit line or converter not idle after reset");
	a_pins_input_rst: assert property (
		$rose(nrst) |-> !general_pin_zero_oe && !general_pin_one_oe && !shared_pin_two_oe)
		else $error("a general pin drives after reset");
	a_sleep_no_conv: assert property (asleep_o |-> !converting_o)
		else $error("converting while asleep");
	a_rdy_from_conv: assert property (
		s_rdy_fall |-> converting_o || $past(converting_o) || $past(converting_o, 2))
		else $error("ready fell with no conversion running");
	a_tx_start_len: assert property (s_tx_start |-> (!tx_pin_o) [*8])
		else $error("start bit too short");
	a_sleep_no_rdy: assert property (asleep_o && shared_pin_two_oe |=> !$fell(shared_pin_two_o))
		else $error("new result while asleep");
	a_start_wakes: assert property ($rose(converting_o) |-> !asleep_o)
		else $error("conversion started while asleep");
endmodule
bind adu_cmd adu_chk u_chk (.clk(clk), .nrst(nrst), .tx_pin_o(tx_pin_o),
	.shared_pin_two_o(shared_pin_two_o), .shared_pin_two_oe(shared_pin_two_oe),
	.general_pin_zero_oe(general_pin_zero_oe), .general_pin_one_oe(general_pin_one_oe),
	.converting_o(converting_o), .asleep_o(asleep_o), .short_inputs_o(short_inputs_o),
	.input_selector_field_o(input_selector_field_o));

// ==== adu_host.sv ====
`timescale 1ns/10ps
module adu_host #(
	parameter int BIT = 16
) (
	input wire logic clk,
	output logic rx_line,
	input wire logic tx_line
);
	logic [7:0] got[$];
	logic [7:0] d;
	initial rx_line = 1'b1;
	// bit time is ours; the device has to measure it from each sync byte
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rx_line = f[i];
			repeat (BIT) @(negedge clk);
		end
	endtask
	task automatic cmd(input logic [7:0] c);
		send(8'h55);
		send(c);
	endtask
	task automatic wr(input logic [7:0] c, input logic [7:0] v);
		cmd(c);
		send(v);
	endtask
	// a low stop bit makes the word unknown so no compare can pass on it
	always begin
		@(negedge tx_line);
		repeat (BIT / 2) @(negedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(negedge clk);
			d[i] = tx_line;
		end
		repeat (BIT) @(negedge clk);
		got.push_back(tx_line === 1'b1 ? d : 8'hxx);
	end
endmodule

// ==== test_adc_uart_command_sequence.sv ====
`timescale 1ns/10ps
module test_adc_uart_command_sequence;
	localparam int BIT = 16;
	localparam int CONV = 600;
	localparam int LIMIT = 40000;
	// 600 us of power-up settling at a 50 ns clock
	localparam int POWER_UP = 12000;
	logic [15:0] offs = 16'h0000;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [15:0] sample = 16'ha5c3;
	logic [2:0] ext = 3'b101;
	logic rx, tx, p0, p1, p2, p0_o, p1_o, p2_o, p0_oe, p1_oe, p2_oe;
	logic conv, sleep, in_short;
	logic [3:0] sel;
	int errors = 0;
	int n_checks = 0;
	int cyc = 0;
	always #25 clk = ~clk;
	assign p0 = p0_oe ? p0_o : ext[0];
	assign p1 = p1_oe ? p1_o : ext[1];
	assign p2 = p2_oe ? p2_o : ext[2];
	adu_host #(.BIT(BIT)) u_host (.clk(clk), .rx_line(rx), .tx_line(tx));
	adu_cmd #(.CONV_CYC(CONV), .RSRX_CYC(20)) u_dut (.clk(clk), .nrst(nrst),
		.rx_pin_i(rx), .tx_pin_o(tx), .sample_i(sample),
		.general_pin_zero_i(p0), .general_pin_zero_o(p0_o), .general_pin_zero_oe(p0_oe),
		.general_pin_one_i(p1), .general_pin_one_o(p1_o), .general_pin_one_oe(p1_oe),
		.shared_pin_two_i(p2), .shared_pin_two_o(p2_o), .shared_pin_two_oe(p2_oe),
		.converting_o(conv), .asleep_o(sleep), .short_inputs_o(in_short),
		.input_selector_field_o(sel));
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk1(input string n, input logic e, input logic g);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %b seen %b", n, e, g);
		end
	endtask
	task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rd(output logic [7:0] b);
		for (int k = 0; k < 40 * BIT && u_host.got.size() == 0; k++) @(negedge clk);
		b = u_host.got.size() > 0 ? u_host.got.pop_front() : 8'hxx;
	endtask
	task automatic register_readback_cmd(input logic [7:0] c, input logic [7:0] e);
		logic [7:0] b;
		u_host.cmd(c);
		rd(b);
		chk8("readback", e, b);
	endtask
	task automatic wait_pin(input logic e, input int n);
		for (int k = 0; k < n && p2_o !== e; k++) @(negedge clk);
	endtask
	task automatic t_reset_state();
		chk1("tx idle", 1'b1, tx);
		chk1("pin0 oe", 1'b0, p0_oe);
		chk1("pin1 oe", 1'b0, p1_oe);
		chk1("pin2 oe", 1'b0, p2_oe);
		chk1("converting", 1'b0, conv);
		register_readback_cmd(8'h28, {5'h00, ext});
		register_readback_cmd(8'h20, 8'h00);
		$display("test reset_state done");
	endtask
	task automatic t_pins();
		u_host.wr(8'h48, 8'h33);
		ext = 3'h2;
		repeat (4) @(negedge clk);
		chk1("pin0 oe", 1'b1, p0_oe);
		chk1("pin1 oe", 1'b1, p1_oe);
		chk1("pin0 out", 1'b1, p0_o);
		chk1("pin1 out", 1'b1, p1_o);
		chk1("pin2 oe", 1'b0, p2_oe);
		register_readback_cmd(8'h28, {5'h06, ext[2], 2'h3});
		$display("test pins done");
	endtask
	task automatic t_short();
		logic [7:0] hi, lo;
		// low nibble asks a gain above 4 with the amplifier left enabled
		u_host.wr(8'h40, 8'he8);
		repeat (4) @(negedge clk);
		chk8("selector", 8'h0e, {4'h0, sel});
		chk1("inputs shorted", 1'b1, in_short);
		register_readback_cmd(8'h20, 8'he8);
		// offset is the mean of shorted readings, taken off later results
		for (int i = 0; i < 2; i++) begin
			sample = 16'h0012 + 16'(4 * i);
			u_host.cmd(8'h08);
			repeat (CONV + 20) @(negedge clk);
			u_host.cmd(8'h10);
			rd(hi);
			rd(lo);
			chk8("offset high", sample[15:8], hi);
			chk8("offset low", sample[7:0], lo);
			offs = offs + {hi, lo};
		end
		offs = offs >> 1;
		sample = 16'ha5c3;
		u_host.wr(8'h40, 8'h00);
		repeat (4) @(negedge clk);
		chk1("inputs shorted", 1'b0, in_short);
		$display("test short done");
	endtask
	task automatic t_stream();
		logic [7:0] hi, lo;
		logic [15:0] fix;
		u_host.wr(8'h42, 8'h08);
		u_host.wr(8'h48, 8'h48);
		repeat (4) @(negedge clk);
		chk1("pin2 oe", 1'b1, p2_oe);
		chk1("pin2 idle", 1'b1, p2_o);
		register_readback_cmd(8'h28, {6'h12, ext[1:0]});
		u_host.cmd(8'h08);
		repeat (4) @(negedge clk);
		chk1("converting", 1'b1, conv);
		wait_pin(1'b0, CONV + 20);
		chk1("ready low", 1'b0, p2_o);
		u_host.cmd(8'h10);
		chk1("ready cleared", 1'b1, p2_o);
		sample = 16'h1e87;
		rd(hi);
		rd(lo);
		chk8("result high", 8'ha5, hi);
		chk8("result low", 8'hc3, lo);
		fix = {hi, lo} - offs;
		chk8("corrected high", 8'ha5, fix[15:8]);
		chk8("corrected low", 8'haf, fix[7:0]);
		wait_pin(1'b0, CONV + 20);
		chk1("next result", 1'b0, p2_o);
		u_host.cmd(8'h02);
		repeat (4) @(negedge clk);
		chk1("converting", 1'b0, conv);
		chk1("asleep", 1'b1, sleep);
		u_host.cmd(8'h10);
		rd(hi);
		rd(lo);
		chk8("held high", 8'h1e, hi);
		chk8("held low", 8'h87, lo);
		wait_pin(1'b0, CONV + 50);
		chk1("quiet asleep", 1'b1, p2_o);
		$display("test stream done");
	endtask
	task automatic t_single();
		u_host.wr(8'h42, 8'h00);
		u_host.cmd(8'h08);
		repeat (4) @(negedge clk);
		chk1("asleep", 1'b0, sleep);
		chk1("converting", 1'b1, conv);
		repeat (CONV + 20) @(negedge clk);
		chk1("one shot", 1'b0, conv);
		$display("test single done");
	endtask
	task automatic t_reset_cmd();
		u_host.wr(8'h40, 8'he8);
		u_host.cmd(8'h06);
		repeat (30) @(negedge clk);
		chk1("inputs shorted", 1'b0, in_short);
		chk1("pin2 oe", 1'b0, p2_oe);
		register_readback_cmd(8'h20, 8'h00);
		$display("test reset_cmd done");
	endtask
	initial begin
		repeat (12) @(negedge clk);
		nrst = 1'b1;
		repeat (POWER_UP) @(negedge clk);
		t_reset_state();
		t_pins();
		t_short();
		t_stream();
		t_single();
		t_reset_cmd();
		give_verdict();
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			errors++;
			give_verdict();
		end
	end
endmodule
